// *** uart2_cfg.svh ***
// constants for the second asynchronous serial port
// Summary of operation
// R1: short format frame is start 0, eight data bits lsb first, stop 1.
// R2: short format stores eight data bits in buffer, stop bit in rx_ninth_bit.
// R3: frame_length_select picks 8 or 9 bit format; bit rate is overflow/16.
// R4: buffer write launches transmission, aligned to next divide-by-16 tick.
// R5: transmitter sends start bit, then data bits in order, then stop bit.
// R6: tx_done_flag sets as stop bit begins; only software writing zero clears.
// R7: receive only while receive_enable is 1; frame starts on falling edge.
// R8: receiver samples at 16x and realigns its divider on falling edge.
// R9: samples at states 7, 8, 9 and takes the two-of-three majority.
// R10: a start bit that reads 1 is dropped and the receiver rearms.
// R11: short format loads only if rx_done_flag 0 and stop check passes.
// R12: long format frame is start, eight data, ninth bit, stop: 11 bits.
// R13: long format copies tx_ninth_bit into the shift register at launch.
// R14: long format stores ninth bit in rx_ninth_bit, data in buffer.
// R15: long format sets rx_done_flag only when stop bit is 1.
// R16: long format with check enabled accepts only ninth bit 1.
// R17: software must clear rx_done_flag before another frame is accepted.
// R18: baud generator must keep bit rate at or below 38400 baud.
// R19: buffer write feeds transmitter; read returns the last received byte.
// R20: reserved bits of control and mode registers read zero, ignore writes.
// R21: transmit pin idles high when no frame is being sent.
`ifndef UART2_CFG_SVH
`define UART2_CFG_SVH
`define OFS_CONTROL 12'h000
`define OFS_MODE 12'h004
`define OFS_BUFFER 12'h008
`define CTL_RX_DONE 0
`define CTL_TX_DONE 1
`define CTL_RX_NINTH 2
`define CTL_TX_NINTH 3
`define CTL_RX_EN 4
`define MODE_CHECK 0
`define MODE_LONG 1
`define CTL_WMASK 8'h1F
`define MODE_WMASK 2'h3
`define STATE_LAST 4'hF
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define BITS_SHORT 4'h9
`define BITS_LONG 4'hA
`define RESET_BYTE 8'h00
`endif

// *** uart2_pkg.sv ***
// types for the second asynchronous serial port
package uart2_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_BITS} rx_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage : uart2_pkg

// *** uart2_port.sv ***
// second asynchronous serial port with apb register access
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "uart2_cfg.svh"
module uart2_port (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire uart2_pkg::apb_req_t apbReq,
   output uart2_pkg::apb_rsp_t apbRsp,
   // baud generator overflow pulse
   input wire logic baudTick,
   // serial pins
   input wire logic serialRxPin,
   output logic serialTxPin
);
   logic [7:0] controlReg;
   logic [1:0] modeReg;
   logic [7:0] rxBufferReg;
   logic [31:0] rdataReg;
   logic [3:0] txDivReg;
   logic txTickNow;
   logic txPendReg;
   logic txBusyReg;
   logic [10:0] txShiftReg;
   logic [3:0] txCountReg;
   logic txPinReg;
   uart2_pkg::rx_state_t rxStateReg;
   logic [3:0] rxDivReg;
   logic [3:0] rxCountReg;
   logic [9:0] rxShiftReg;
   logic [1:0] voteReg;
   logic rxPrevReg;
   logic rxBit;
   logic rxLoad;
   logic rxSetDone;
   logic [9:0] rxFrame;
   logic wrAcc;
   logic wrCtl;
   logic wrBuf;
   logic txStop;
   logic isLong;

   assign isLong = modeReg[`MODE_LONG];
   assign wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign wrCtl = wrAcc & (apbReq.paddr == `OFS_CONTROL);
   assign wrBuf = wrAcc & (apbReq.paddr == `OFS_BUFFER);

   // zero-wait slave; unmapped addresses answer slverr
   always_comb begin
      apbRsp.pready = 1'b1;
      apbRsp.prdata = rdataReg;
      apbRsp.pslverr = apbReq.psel & apbReq.penable &
         (apbReq.paddr != `OFS_CONTROL) & (apbReq.paddr != `OFS_MODE) &
         (apbReq.paddr != `OFS_BUFFER);
   end

   // read data registered in setup phase, stable through access
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdataReg <= 32'h0000_0000;
      end else if (apbReq.psel & ~apbReq.penable) begin
         unique case (apbReq.paddr)
            `OFS_CONTROL: rdataReg <= {24'h00_0000, controlReg}; // see R20
            `OFS_MODE: rdataReg <= {30'h0000_0000, modeReg}; // see R20
            `OFS_BUFFER: rdataReg <= {24'h00_0000, rxBufferReg}; // see R19
            default: rdataReg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         modeReg <= 2'h0;
      end else if (wrAcc & (apbReq.paddr == `OFS_MODE)) begin
         modeReg <= apbReq.pwdata[1:0] & `MODE_WMASK; // see R3 see R20
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         controlReg <= `RESET_BYTE;
      end else begin
         // later assignments below win over this software write
         if (wrCtl) begin
            controlReg <= apbReq.pwdata[7:0] & `CTL_WMASK; // see R20
         end
         if (txStop) begin
            controlReg[`CTL_TX_DONE] <= 1'b1; // see R6
         end
         if (rxSetDone) begin
            controlReg[`CTL_RX_DONE] <= 1'b1; // see R11 see R15 see R17
         end
         if (rxLoad) begin
            // short: stop bit; long: ninth bit (see R2 see R14)
            controlReg[`CTL_RX_NINTH] <= isLong ? rxFrame[9] : rxBit;
         end
      end
   end

   // transmit divide-by-16 runs free off the baud ticks
   always_ff @(posedge mclk) begin
      if (rst) begin
         txDivReg <= 4'h0;
      end else if (baudTick) begin
         txDivReg <= txDivReg + 4'h1; // see R3
      end
   end
   assign txTickNow = baudTick & (txDivReg == `STATE_LAST);

   // transmitter; start waits for the next counter wrap
   assign txStop = txBusyReg & txTickNow &
      (txCountReg == (isLong ? `BITS_LONG : `BITS_SHORT) - 4'h1);
   always_ff @(posedge mclk) begin
      if (rst) begin
         txPendReg <= 1'b0;
         txBusyReg <= 1'b0;
         txShiftReg <= 11'h7FF;
         txCountReg <= 4'h0;
         txPinReg <= 1'b1;
      end else begin
         if (wrBuf) begin
            txPendReg <= 1'b1; // see R4
            // stop bits above the data, ninth bit for long frames
            txShiftReg <= isLong ?
               {1'b1, controlReg[`CTL_TX_NINTH], apbReq.pwdata[7:0], 1'b0} :
               {2'h3, apbReq.pwdata[7:0], 1'b0}; // see R13 see R1 see R12
            txCountReg <= 4'h0;
            txBusyReg <= 1'b0;
            txPinReg <= 1'b1;
         end else if (txTickNow) begin
            if (txPendReg) begin
               txPendReg <= 1'b0;
               txBusyReg <= 1'b1;
               txPinReg <= txShiftReg[0]; // see R5
               txShiftReg <= {1'b1, txShiftReg[10:1]};
               txCountReg <= 4'h0;
            end else if (txBusyReg) begin
               if (txCountReg == (isLong ? `BITS_LONG : `BITS_SHORT)) begin
                  txBusyReg <= 1'b0;
                  txPinReg <= 1'b1; // see R21
               end else begin
                  txPinReg <= txShiftReg[0]; // see R5
                  txShiftReg <= {1'b1, txShiftReg[10:1]};
                  txCountReg <= txCountReg + 4'h1;
               end
            end
         end
      end
   end
   assign serialTxPin = txPinReg;

   // receiver
   assign rxBit = (voteReg == 2'h2) ? (voteReg[1] | serialRxPin) :
      (voteReg[1] | (voteReg[0] & serialRxPin)); // see R9
   assign rxFrame = rxShiftReg;
   assign rxLoad = (rxStateReg == uart2_pkg::RX_BITS) & baudTick &
      (rxDivReg == `SAMPLE_C) &
      (rxCountReg == (isLong ? `BITS_LONG : `BITS_SHORT)) &
      ~controlReg[`CTL_RX_DONE] &
      (isLong ? (~modeReg[`MODE_CHECK] | rxShiftReg[9]) :
                (~modeReg[`MODE_CHECK] | rxBit)); // see R11 see R16
   assign rxSetDone = rxLoad & (isLong ? rxBit : 1'b1); // see R15

   always_ff @(posedge mclk) begin
      if (rst) begin
         rxPrevReg <= 1'b1;
      end else begin
         rxPrevReg <= serialRxPin;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rxStateReg <= uart2_pkg::RX_IDLE;
         rxDivReg <= 4'h0;
         rxCountReg <= 4'h0;
         rxShiftReg <= 10'h000;
         voteReg <= 2'h0;
      end else begin
         unique case (rxStateReg)
            uart2_pkg::RX_IDLE: begin
               if (controlReg[`CTL_RX_EN] & rxPrevReg & ~serialRxPin) begin
                  rxStateReg <= uart2_pkg::RX_BITS; // see R7
                  rxDivReg <= 4'h0; // see R8
                  rxCountReg <= 4'h0;
                  voteReg <= 2'h0;
               end
            end
            uart2_pkg::RX_BITS: begin
               if (~controlReg[`CTL_RX_EN]) begin
                  rxStateReg <= uart2_pkg::RX_IDLE; // see R7
               end else if (baudTick) begin
                  rxDivReg <= rxDivReg + 4'h1; // see R8
                  // vote holds the count of ones seen so far
                  if ((rxDivReg == `SAMPLE_A) | (rxDivReg == `SAMPLE_B)) begin
                     voteReg <= voteReg + {1'b0, serialRxPin}; // see R9
                  end
                  if (rxDivReg == `SAMPLE_C) begin
                     voteReg <= 2'h0;
                     if ((rxCountReg == 4'h0) & rxBit) begin
                        rxStateReg <= uart2_pkg::RX_IDLE; // see R10
                     end else if (rxCountReg ==
                        (isLong ? `BITS_LONG : `BITS_SHORT)) begin
                        rxStateReg <= uart2_pkg::RX_IDLE;
                     end else begin
                        rxShiftReg <= {rxBit, rxShiftReg[9:1]};
                        rxCountReg <= rxCountReg + 4'h1;
                     end
                  end
               end
            end
            default: rxStateReg <= uart2_pkg::RX_IDLE;
         endcase
      end
   end

   // receive buffer kept apart from the transmit shifter
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxBufferReg <= `RESET_BYTE;
      end else if (rxLoad) begin
         // short: shift holds start..d7, stop is rxBit
         rxBufferReg <= isLong ? rxShiftReg[8:1] : rxShiftReg[9:2];
      end
   end
endmodule : uart2_port
`default_nettype wire

// *** uart2_port_asserts.sv ***
// checker on the serial port ports
`timescale 1ns/1ps
`default_nettype none
module uart2_port_asserts (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bus, tick and pins
   input wire uart2_pkg::apb_req_t apbReq,
   input wire uart2_pkg::apb_rsp_t apbRsp,
   input wire logic baudTick,
   input wire logic serialRxPin,
   input wire logic serialTxPin
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic acc;
   assign acc = apbReq.psel && apbReq.penable;
   idle_high_a: assert property ($fell(rst) |-> serialTxPin)
      else $error("tx low after reset");
   tick_paced_a: assert property ($changed(serialTxPin) && !$past(rst)
      |-> $past(baudTick)) else $error("tx moved off tick");
   tx_launch_a: assert property (acc && apbReq.pwrite &&
      apbReq.paddr == 12'h008 |-> ##[1:300] !serialTxPin)
      else $error("no start bit");
   low_bit_a: assert property ($fell(serialTxPin) |-> !serialTxPin[*8])
      else $error("short low bit");
   high_bit_a: assert property ($rose(serialTxPin) && !$past(rst)
      |-> serialTxPin[*8]) else $error("short high bit");
   ctl_zero_a: assert property (acc && !apbReq.pwrite &&
      apbReq.paddr == 12'h000 |-> apbRsp.prdata[31:5] == 27'h0)
      else $error("control reserved bits set");
   mode_zero_a: assert property (acc && !apbReq.pwrite &&
      apbReq.paddr == 12'h004 |-> apbRsp.prdata[31:2] == 30'h0)
      else $error("mode reserved bits set");
   buf_mapped_a: assert property (acc && apbReq.paddr == 12'h008
      |-> !apbRsp.pslverr) else $error("buffer refused");
endmodule : uart2_port_asserts
bind uart2_port uart2_port_asserts chk_u (.mclk(mclk), .rst(rst),
   .apbReq(apbReq), .apbRsp(apbRsp), .baudTick(baudTick),
   .serialRxPin(serialRxPin), .serialTxPin(serialTxPin));
`default_nettype wire

// *** uart2_remote.sv ***
// remote serial transceiver model
`timescale 1ns/1ps
`default_nettype none
module uart2_remote (
   // clock and tick
   input wire logic mclk,
   input wire logic baudTick,
   // serial lines
   input wire logic txLine,
   output logic rxLine
);
   initial rxLine = 1'b1;
   task automatic tk(input int k);
      repeat (k) begin
         do @(posedge mclk); while (baudTick !== 1'b1);
      end
   endtask : tk
   // bit 0 first; line returns high as an idle uart line does
   task automatic sendFrame(input int n, input int t, input logic [10:0] b);
      for (int i = 0; i < n; i++) begin
         rxLine <= b[i];
         tk(t);
      end
      rxLine <= 1'b1;
   endtask : sendFrame
   // mid-bit sampling from the falling start edge
   task automatic getFrame(input int n, output logic [10:0] b);
      b = '0;
      @(negedge txLine);
      tk(8);
      for (int i = 0; i < n; i++) begin
         b[i] = txLine;
         if (i < n - 1) tk(16);
      end
   endtask : getFrame
endmodule : uart2_remote
`default_nettype wire

// *** second_async_serial_port_test.sv ***
// self-checking bench for the second serial port
`timescale 1ns/1ps
`default_nettype none
module second_async_serial_port_test;
   logic mclk;
   logic rst;
   logic baudTick = 1'b0;
   logic rxPin;
   logic txPin;
   logic er;
   uart2_pkg::apb_req_t req;
   uart2_pkg::apb_rsp_t rsp;
   logic [31:0] rd;
   logic [31:0] ex;
   logic [10:0] fr;
   logic [7:0] dat [2] = '{8'hA5, 8'h3C};
   int errors = 0;
   int n_checks = 0;
   int tcnt = 0;
   int cyc = 0;
   // receive cases: control (-1 keeps flags), mode, bits, frame, done, buffer
   int cCtl [8] = '{16, -1, 16, 16, 16, 16, 0, 16};
   int cMod [8] = '{0, 0, 3, 3, 2, 1, 0, 0};
   int cLen [8] = '{10, 10, 11, 11, 11, 10, 10, 1};
   logic [10:0] cFr [8] = '{11'h32C, 11'h222, 11'h442, 11'h6B4, 11'h2EE,
      11'h088, 11'h21E, 11'h000};
   logic [7:0] cDn = 8'h0B;
   logic [7:0] cNb = 8'h1B;
   logic [7:0] cBuf [8] = '{8'h96, 8'h96, 8'h96, 8'h5A, 8'h77, 8'h77,
      8'h77, 8'h77};
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   uart2_port dut_u (.mclk(mclk), .rst(rst), .apbReq(req), .apbRsp(rsp),
      .baudTick(baudTick), .serialRxPin(rxPin), .serialTxPin(txPin));
   uart2_remote remote_u (.mclk(mclk), .baudTick(baudTick), .txLine(txPin),
      .rxLine(rxPin));
   // 17 clocks a tick keeps the bit rate under the port's ceiling
   always @(posedge mclk) begin
      tcnt <= (tcnt == 16) ? 0 : tcnt + 1;
      baudTick <= (tcnt == 16);
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k = 0;
      @(posedge mclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 50);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer
   task automatic rdChk(input string nm, input logic [11:0] a,
      input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdChk
   initial begin
      req = '0;
      rst = 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rdChk("control", 12'h000, 32'h0);
      rdChk("mode", 12'h004, 32'h0);
      rdChk("buffer", 12'h008, 32'h0);
      xfer(1'b0, 12'h00C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      xfer(1'b1, 12'h000, 32'hFF);
      rdChk("control mask", 12'h000, 32'h1F);
      xfer(1'b1, 12'h004, 32'hFF);
      rdChk("mode mask", 12'h004, 32'h3);
      $display("register test done");
      for (int m = 0; m < 2; m++) begin
         xfer(1'b1, 12'h000, 32'h08);
         xfer(1'b1, 12'h004, {30'h0, m[0], 1'b0});
         fork
            remote_u.getFrame(10 + m, fr);
            begin
               xfer(1'b1, 12'h008, {24'h0, dat[m]});
               // ninth bit must be latched at launch, so drop it now
               xfer(1'b1, 12'h000, 32'h0);
            end
         join
         ex = {21'h0, m[0], 1'b1, dat[m], 1'b0};
         chk("tx frame", ex, {21'h0, fr});
         rdChk("tx done", 12'h000, 32'h2);
         remote_u.tk(16);
      end
      $display("transmit test done");
      for (int i = 0; i < 8; i++) begin
         if (cCtl[i] >= 0) xfer(1'b1, 12'h000, 32'(cCtl[i]));
         xfer(1'b1, 12'h004, 32'(cMod[i]));
         remote_u.sendFrame(cLen[i], cLen[i] == 1 ? 3 : 16, cFr[i]);
         remote_u.tk(16);
         xfer(1'b0, 12'h000, 32'h0);
         chk("rx done", {31'h0, cDn[i]}, {31'h0, rd[0]});
         chk("rx ninth", {31'h0, cNb[i]}, {31'h0, rd[2]});
         rdChk("rx buffer", 12'h008, {24'h0, cBuf[i]});
      end
      $display("receive test done");
      give_verdict();
   end
endmodule : second_async_serial_port_test
`default_nettype wire
